// ===== core/evi_arbiter.v
/*
 priority arbiter over all event and software interrupt requests.
 assumes requests already gated by enables; highest priority above mask wins, lower source index on ties.
*/
`default_nettype none
`include "evi_defs.vh"

module evi_arbiter (
    input wire [`EVI_NUM_SRC-1:0] req,
    input wire [`EVI_NUM_SRC*`EVI_PRIO_W-1:0] prio,
    input wire [3:0] mask_level,
    output reg found,
    output reg [4:0] win_idx,
    output reg [3:0] win_prio
);
    integer i;
    reg [3:0] p;
    always @* begin
        found = 1'b0;
        win_idx = 5'h00;
        win_prio = `EVI_PRIO_NONE;
        p = 4'h0;
        // strictly greater keeps the lower index on ties
        for (i = 0; i < `EVI_NUM_SRC; i = i + 1) begin
            p = prio[i*`EVI_PRIO_W +: `EVI_PRIO_W];
            if (req[i] && (p > mask_level) && (!found || p > win_prio)) begin
                found = 1'b1;
                win_idx = i[4:0];
                win_prio = p;
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/evi_defs.vh
/*
 event interrupt vectoring constants: vector addresses, ranks, reset values.
 assumes nothing beyond a verilog-2005 compiler; included by bare name.
*/
`ifndef EVI_DEFS_VH
`define EVI_DEFS_VH

`define EVI_VEC_RESET 16'h0000
`define EVI_VEC_BRKPT 16'h0004
`define EVI_VEC_TRACE 16'h0008
`define EVI_VEC_STKOV 16'h000C
`define EVI_VEC_DIVZ 16'h0010
`define EVI_VEC_URET 16'h0014
`define EVI_VEC_TRAP_BASE 16'h0040
`define EVI_VEC_EVT_BASE 16'h0080
`define EVI_VEC_PCA_CH_BASE 16'h00C0
`define EVI_VEC_SOFT_BASE 16'h00FC
`define EVI_VEC_SLOT 16'h0004

`define EVI_RANK_RESET 5'h00
`define EVI_RANK_EXC 5'h01
`define EVI_RANK_PCA_CH0 5'h11
`define EVI_RANK_TWOWIRE 5'h16
`define EVI_RANK_SOFT 5'h17

`define EVI_NUM_HW 17
`define EVI_NUM_SW 7
`define EVI_NUM_SRC 24
`define EVI_PRIO_W 4
`define EVI_PRIO_NONE 4'h0
`define EVI_VEC_RST_VAL 16'h0000

`endif

// ===== core/evi_top.v
/*
 exception, trap and event interrupt vectoring with low-power wake-up.
 assumes synchronous flag inputs from peripherals and a core that takes vectors.
*/
`default_nettype none
`include "evi_defs.vh"

module evi_top (
    input wire clk,
    input wire rst,
    input wire reset_any,
    input wire exc_breakpoint,
    input wire exc_trace,
    input wire exc_stack_overflow,
    input wire exc_divide_zero,
    input wire exc_user_return,
    input wire trap_req,
    input wire [3:0] trap_num,
    input wire global_irq_enable,
    input wire [3:0] mask_level,
    input wire ext_irq0_flag,
    input wire ext_irq1_flag,
    input wire ext_irq0_enable,
    input wire ext_irq1_enable,
    input wire timer0_overflow_flag,
    input wire timer1_overflow_flag,
    input wire timer2_overflow_flag,
    input wire timer2_external_flag,
    input wire timer0_irq_enable,
    input wire timer1_irq_enable,
    input wire timer2_irq_enable,
    input wire pca_counter_overflow_flag,
    input wire [4:0] pca_ch_flag,
    input wire pca_global_irq_enable,
    input wire [4:0] pca_ch_irq_enable,
    input wire converter_done_flag,
    input wire converter_irq_enable,
    input wire uart0_rx_flag,
    input wire uart0_tx_flag,
    input wire uart1_rx_flag,
    input wire uart1_tx_flag,
    input wire uart0_rx_irq_enable,
    input wire uart0_tx_irq_enable,
    input wire uart1_rx_irq_enable,
    input wire uart1_tx_irq_enable,
    input wire twowire_event_flag,
    input wire twowire_irq_enable,
    input wire [7:0] priority_bank_a_reg0,
    input wire [7:0] priority_bank_a_reg1,
    input wire [7:0] priority_bank_a_reg2,
    input wire [7:0] priority_bank_a_reg3,
    input wire [7:0] priority_bank_a_reg4,
    input wire [7:0] priority_bank_a_reg5,
    input wire [7:0] priority_bank_b_reg0,
    input wire [7:0] priority_bank_b_reg1,
    input wire [7:0] priority_bank_b_reg2,
    input wire [7:1] soft_irq_request,
    input wire [7:1] soft_irq_enable,
    input wire idle_enter,
    input wire powerdown_enter,
    input wire vector_ack,
    output reg vector_valid_r,
    output reg [15:0] vector_addr_r,
    output reg [4:0] vector_rank_r,
    output reg [3:0] vector_prio_r,
    output reg is_event_r,
    output wire irq_pending,
    output reg core_stall_r,
    output reg osc_enable_r
);
    localparam ST_RUN = 3'b001;
    localparam ST_IDLE = 3'b010;
    localparam ST_PDOWN = 3'b100;

    reg [2:0] state_r;
    reg [2:0] state_nxt;

    function [15:0] slot_addr;
        input [15:0] base;
        input [4:0] idx;
        begin
            slot_addr = base + {9'h000, idx, 2'b00};
        end
    endfunction

    function [3:0] nib;
        input [7:0] r;
        input hi;
        begin
            nib = hi ? r[7:4] : r[3:0];
        end
    endfunction

    wire [`EVI_NUM_SRC-1:0] req;
    wire [`EVI_NUM_SRC*`EVI_PRIO_W-1:0] prio;
    wire g = global_irq_enable;

    assign req[0] = g & ext_irq0_enable & ext_irq0_flag;
    assign req[1] = g & timer0_irq_enable & timer0_overflow_flag;
    assign req[2] = g & ext_irq1_enable & ext_irq1_flag;
    assign req[3] = g & timer1_irq_enable & timer1_overflow_flag;
    assign req[4] = g & timer2_irq_enable & (timer2_overflow_flag | timer2_external_flag);
    assign req[5] = g & pca_global_irq_enable & (|pca_ch_flag | pca_counter_overflow_flag);
    assign req[6] = g & converter_irq_enable & converter_done_flag;
    assign req[7] = g & uart0_rx_irq_enable & uart0_rx_flag;
    assign req[8] = g & uart0_tx_irq_enable & uart0_tx_flag;
    assign req[9] = g & uart1_rx_irq_enable & uart1_rx_flag;
    assign req[10] = g & uart1_tx_irq_enable & uart1_tx_flag;
    assign req[15:11] = {5{g}} & pca_ch_irq_enable & pca_ch_flag;
    // flag held until software clears it; no auto clear here
    assign req[16] = g & twowire_irq_enable & twowire_event_flag;
    assign req[23:17] = {7{g}} & soft_irq_enable & soft_irq_request;

    assign prio[3:0] = nib(priority_bank_a_reg0, 1'b0);
    assign prio[7:4] = nib(priority_bank_a_reg0, 1'b1);
    assign prio[11:8] = nib(priority_bank_a_reg1, 1'b0);
    assign prio[15:12] = nib(priority_bank_a_reg1, 1'b1);
    assign prio[19:16] = nib(priority_bank_a_reg2, 1'b0);
    assign prio[23:20] = nib(priority_bank_a_reg2, 1'b1);
    assign prio[27:24] = nib(priority_bank_a_reg3, 1'b0);
    assign prio[31:28] = nib(priority_bank_a_reg4, 1'b0);
    assign prio[35:32] = nib(priority_bank_a_reg4, 1'b1);
    assign prio[39:36] = nib(priority_bank_a_reg5, 1'b0);
    assign prio[43:40] = nib(priority_bank_a_reg5, 1'b1);
    assign prio[47:44] = nib(priority_bank_b_reg0, 1'b0);
    assign prio[51:48] = nib(priority_bank_b_reg0, 1'b1);
    assign prio[55:52] = nib(priority_bank_b_reg1, 1'b0);
    assign prio[59:56] = nib(priority_bank_b_reg1, 1'b1);
    assign prio[63:60] = nib(priority_bank_b_reg2, 1'b0);
    assign prio[67:64] = nib(priority_bank_b_reg2, 1'b1);
    // software priorities fixed at index
    assign prio[95:68] = {4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};

    wire found;
    wire [4:0] win_idx;
    wire [3:0] win_prio;

    evi_arbiter u_arb (
        .req(req),
        .prio(prio),
        .mask_level(mask_level),
        .found(found),
        .win_idx(win_idx),
        .win_prio(win_prio)
    );

    assign irq_pending = found;

    // event index to vector and rank
    reg [15:0] evt_addr;
    reg [4:0] evt_rank;
    always @* begin
        evt_addr = `EVI_VEC_RESET;
        evt_rank = `EVI_RANK_RESET;
        case (win_idx)
            5'd0, 5'd1, 5'd2, 5'd3: begin
                // external and timer 0/1 slots follow the index
                evt_addr = slot_addr(`EVI_VEC_EVT_BASE, win_idx);
                evt_rank = win_idx + 5'd2;
            end
            5'd4, 5'd5, 5'd6: begin
                evt_addr = slot_addr(`EVI_VEC_EVT_BASE, win_idx);
                evt_rank = win_idx + 5'd2;
            end
            5'd7, 5'd8: begin
                // one empty slot before the uart group
                evt_addr = slot_addr(`EVI_VEC_EVT_BASE, win_idx + 5'd1);
                evt_rank = win_idx + 5'd2;
            end
            5'd9, 5'd10: begin
                evt_addr = slot_addr(`EVI_VEC_EVT_BASE, win_idx + 5'd1);
                evt_rank = win_idx + 5'd2;
            end
            5'd11, 5'd12, 5'd13, 5'd14, 5'd15: begin
                // channel slots from their own base
                evt_addr = slot_addr(`EVI_VEC_PCA_CH_BASE, win_idx - 5'd11);
                evt_rank = win_idx - 5'd11 + `EVI_RANK_PCA_CH0;
            end
            5'd16: begin
                evt_addr = slot_addr(`EVI_VEC_PCA_CH_BASE, 5'd5);
                evt_rank = `EVI_RANK_TWOWIRE;
            end
            default: begin
                // soft slots one through seven
                evt_addr = slot_addr(`EVI_VEC_SOFT_BASE, win_idx - 5'd16);
                evt_rank = `EVI_RANK_SOFT;
            end
        endcase
    end

    // exceptions outrank events; reset outranks all
    reg sel_valid;
    reg [15:0] sel_addr;
    reg [4:0] sel_rank;
    reg sel_evt;
    always @* begin
        sel_valid = 1'b1;
        sel_addr = `EVI_VEC_RESET;
        sel_rank = `EVI_RANK_EXC;
        sel_evt = 1'b0;
        if (reset_any) begin
            sel_rank = `EVI_RANK_RESET;
        end else if (exc_breakpoint) begin
            sel_addr = `EVI_VEC_BRKPT;
        end else if (exc_trace) begin
            sel_addr = `EVI_VEC_TRACE;
        end else if (exc_stack_overflow) begin
            sel_addr = `EVI_VEC_STKOV;
        end else if (exc_divide_zero) begin
            sel_addr = `EVI_VEC_DIVZ;
        end else if (exc_user_return) begin
            sel_addr = `EVI_VEC_URET;
        end else if (trap_req) begin
            sel_addr = slot_addr(`EVI_VEC_TRAP_BASE, {1'b0, trap_num});
        end else if (found) begin
            sel_addr = evt_addr;
            sel_rank = evt_rank;
            sel_evt = 1'b1;
        end else begin
            sel_valid = 1'b0;
        end
    end

    // wake from power-down via reset_any or an enabled ext irq above mask
    wire wake0 = g & ext_irq0_enable & ext_irq0_flag & (prio[3:0] > mask_level);
    wire wake1 = g & ext_irq1_enable & ext_irq1_flag & (prio[11:8] > mask_level);
    wire ext_wake = wake0 | wake1;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (powerdown_enter)
                    state_nxt = ST_PDOWN;
                else if (idle_enter)
                    state_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                if (sel_valid)
                    state_nxt = ST_RUN;
            end
            ST_PDOWN: begin
                if (reset_any || ext_wake)
                    state_nxt = ST_RUN;
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    wire take_new = !vector_valid_r || vector_ack;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_RUN;
            core_stall_r <= 1'b0;
            osc_enable_r <= 1'b1;
            vector_valid_r <= 1'b1;
            vector_addr_r <= `EVI_VEC_RST_VAL;
            vector_rank_r <= `EVI_RANK_RESET;
            vector_prio_r <= `EVI_PRIO_NONE;
            is_event_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            core_stall_r <= (state_nxt != ST_RUN);
            // oscillator off in power-down; held state untouched
            osc_enable_r <= (state_nxt != ST_PDOWN);
            // stalled core takes no vector; choice made again on wake
            if (state_nxt != ST_RUN) begin
                vector_valid_r <= 1'b0;
            end else if (take_new) begin
                vector_valid_r <= sel_valid;
            end
            if (take_new) begin
                vector_addr_r <= sel_addr;
                vector_rank_r <= sel_rank;
                vector_prio_r <= sel_evt ? win_prio : `EVI_PRIO_NONE;
                is_event_r <= sel_evt;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/evi_chk.sv
/* evi_chk: assertions on the vector and power outputs of evi_top.
 bound to evi_top from the testbench; sees its ports only. */
`default_nettype none
module evi_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_any,
    input wire logic vector_ack,
    input wire logic vector_valid_r,
    input wire logic [15:0] vector_addr_r,
    input wire logic [4:0] vector_rank_r,
    input wire logic [3:0] vector_prio_r,
    input wire logic is_event_r,
    input wire logic core_stall_r,
    input wire logic osc_enable_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_HOLD: assert property (vector_valid_r && !vector_ack |=>
        !vector_valid_r || $stable(vector_addr_r)) else $error("vector moved before ack");
    AST_RST_VEC: assert property ($fell(rst) |->
        vector_valid_r && vector_addr_r == 16'h0000 && vector_rank_r == 5'h00) else $error("no reset vector");
    AST_RESET_ANY: assert property (reset_any && vector_ack && !core_stall_r
        |=> vector_rank_r == 5'h00 && vector_addr_r == 16'h0000) else $error("reset request not vectored");
    AST_EXC: assert property (vector_valid_r && vector_rank_r == 5'h01 |->
        vector_prio_r == 4'h0 && !is_event_r && vector_addr_r inside {[16'h0004:16'h007C]})
        else $error("bad exception vector");
    AST_EVT: assert property (vector_valid_r && is_event_r |->
        vector_rank_r inside {[5'h02:5'h17]} && vector_prio_r != 4'h0) else $error("bad event vector");
    AST_SOFT: assert property (vector_valid_r && vector_rank_r == 5'h17 |->
        vector_addr_r == 16'h00FC + {10'h000, vector_prio_r, 2'b00}) else $error("bad soft vector");
    AST_PWR: assert property (core_stall_r || !osc_enable_r |->
        core_stall_r && !vector_valid_r) else $error("vector while stalled");
    AST_WAKE: assert property (!osc_enable_r && reset_any |-> ##[1:3] osc_enable_r)
        else $error("no wake on reset");
endmodule
`default_nettype wire

// ===== sim/evi_core_model.sv
/* evi_core_model: core that takes each vector with a one-cycle ack.
 slow sets the wait, 1 to 4 cycles, between a valid vector and its ack. */
`default_nettype none
module evi_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic vector_valid_r,
    input wire logic [1:0] slow,
    output logic vector_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_r;
    always @(posedge clk or posedge rst) begin
        if (rst || vector_ack || !vector_valid_r) begin
            vector_ack <= 1'b0;
            wait_r <= 2'h0;
        end else if (wait_r == slow) begin
            vector_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
/* testbench: corner and random requests into evi_top, checked against a model.
 assumes evi_top, evi_core_model and evi_chk are compiled first. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, global_irq_enable = 1'b0, idle_enter = 1'b0, powerdown_enter = 1'b0;
    logic [17:0] flg = 18'h0;
    logic [16:0] ena = 17'h0;
    logic [71:0] pr = 72'h0;
    logic [6:0] exc = 7'h0, sreq = 7'h0, sen = 7'h0;
    logic [3:0] trap_num = 4'h0, mask_level = 4'h0, vector_prio_r;
    logic [1:0] slow = 2'h0;
    logic [31:0] seed = 32'h960431E7;
    logic vector_ack, vector_valid_r, is_event_r, irq_pending, core_stall_r, osc_enable_r;
    logic [15:0] vector_addr_r;
    logic [4:0] vector_rank_r;
    int error_cnt = 0, comparisons = 0;
    logic pend_exp = 1'b0;
    evi_top evi_top_i (.clk, .rst, .reset_any(exc[6]), .exc_breakpoint(exc[5]), .exc_trace(exc[4]),
        .exc_stack_overflow(exc[3]), .exc_divide_zero(exc[2]), .exc_user_return(exc[1]), .trap_req(exc[0]),
        .trap_num, .global_irq_enable, .mask_level, .ext_irq0_flag(flg[0]), .timer0_overflow_flag(flg[1]),
        .ext_irq1_flag(flg[2]), .timer1_overflow_flag(flg[3]), .timer2_overflow_flag(flg[4]),
        .timer2_external_flag(flg[5]), .pca_counter_overflow_flag(flg[6]), .converter_done_flag(flg[7]),
        .uart0_rx_flag(flg[8]), .uart0_tx_flag(flg[9]), .uart1_rx_flag(flg[10]), .uart1_tx_flag(flg[11]),
        .pca_ch_flag(flg[16:12]), .twowire_event_flag(flg[17]), .ext_irq0_enable(ena[0]),
        .timer0_irq_enable(ena[1]), .ext_irq1_enable(ena[2]), .timer1_irq_enable(ena[3]),
        .timer2_irq_enable(ena[4]), .pca_global_irq_enable(ena[5]), .converter_irq_enable(ena[6]),
        .uart0_rx_irq_enable(ena[7]), .uart0_tx_irq_enable(ena[8]), .uart1_rx_irq_enable(ena[9]),
        .uart1_tx_irq_enable(ena[10]), .pca_ch_irq_enable(ena[15:11]), .twowire_irq_enable(ena[16]),
        .priority_bank_a_reg0(pr[7:0]), .priority_bank_a_reg1(pr[15:8]), .priority_bank_a_reg2(pr[23:16]),
        .priority_bank_a_reg3(pr[31:24]), .priority_bank_a_reg4(pr[39:32]), .priority_bank_a_reg5(pr[47:40]),
        .priority_bank_b_reg0(pr[55:48]), .priority_bank_b_reg1(pr[63:56]), .priority_bank_b_reg2(pr[71:64]),
        .soft_irq_request(sreq), .soft_irq_enable(sen), .idle_enter, .powerdown_enter, .vector_ack,
        .vector_valid_r, .vector_addr_r, .vector_rank_r, .vector_prio_r, .is_event_r, .irq_pending,
        .core_stall_r, .osc_enable_r);
    evi_core_model evi_core_model_i (.clk, .rst, .vector_valid_r, .slow, .vector_ack);
    always #20 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected {valid, event, prio, rank, addr}
    function automatic logic [26:0] expect_vec();
        logic [16:0] rq;
        logic [26:0] e;
        logic [4:0] r;
        logic [3:0] p, best;
        e = 27'h0;
        best = mask_level;
        rq = {flg[17], flg[16:12], flg[11:7], flg[6] | (|flg[16:12]), flg[4] | flg[5], flg[3:0]};
        rq = rq & ena & {17{global_irq_enable}};
        for (int j = 0; j < 17; j++) begin
            r = j <= 10 ? 5'(j + 2) : 5'(j + 6);
            p = pr[4 * (j <= 6 ? j : j + 1) +: 4];
            if (rq[j] && p > best) begin
                best = p;
                e = {2'b11, p, r, r <= 5'h08 ? 16'h0078 + 16'(4 * r) : 16'h007C + 16'(4 * r)};
            end
        end
        for (int i = 1; i < 8; i++)
            if (sreq[i - 1] && sen[i - 1] && 4'(i) > best) begin
                best = 4'(i);
                e = {2'b11, 4'(i), 5'h17, 16'h00FC + 16'(4 * i)};
            end
        pend_exp = e[26];
        for (int i = 0; i < 7; i++)
            if (exc[i]) e = {2'b10, 4'h0, i == 6 ? 5'h00 : 5'h01, i > 0 ? 16'(24 - 4 * i) : 16'h0040 + 16'(4 * trap_num)};
        return e;
    endfunction
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask
    // 0: ack or idle vector, 1: oscillator on, 2: core running
    task automatic wait_until(input int sel);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < 60 && !(sel == 0 ? vector_ack === 1'b1 || vector_valid_r === 1'b0 :
            sel == 1 ? osc_enable_r === 1'b1 : core_stall_r === 1'b0));
        if (n >= 60) begin
            error_cnt++;
            $display("BAD %0t wait ran out", $time);
            print_verdict();
        end
    endtask
    task automatic run_case();
        logic [26:0] e;
        repeat (2) @(posedge clk);
        wait_until(0);
        @(posedge clk);
        #1;
        e = expect_vec();
        chk(vector_valid_r ? {vector_valid_r, is_event_r, vector_prio_r, vector_rank_r, vector_addr_r} : 27'h0, e);
        chk(irq_pending, pend_exp);
    endtask
    initial begin
        logic [127:0] w;
        logic [31:0] v;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({vector_valid_r, vector_rank_r, vector_addr_r}, {1'b1, 5'h00, 16'h0000});
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {flg, ena, pr, mask_level, global_irq_enable} <= {18'h3FFFF, 17'h1FFFF, {72{1'b1}}, 4'h0, 1'b1};
            exc <= i < 7 ? 7'h7F >> i : 7'h01;
            trap_num <= i == 6 ? 4'h0 : 4'hF;
            run_case();
        end
        for (int j = 0; j < 18; j++) begin
            @(posedge clk);
            exc <= 7'h0;
            mask_level <= j < 17 ? 4'h1 : 4'hE;
            pr <= j < 17 ? {18{4'h1}} | (72'h2 << (4 * (j <= 6 ? j : j + 1))) : {72{1'b1}};
            run_case();
        end
        for (int i = 1; i < 8; i++) begin
            @(posedge clk);
            {flg, mask_level, sen} <= {18'h0, 4'h0, 7'h7F};
            sreq <= 7'h7F >> (7 - i);
            run_case();
        end
        for (int n = 0; n < 400; n++) begin
            @(posedge clk);
            w = {rnd(), rnd(), rnd(), rnd()};
            v = rnd();
            {flg, ena, pr} <= w[106:0];
            {global_irq_enable, trap_num, slow, sen} <= {v[2:0] != 3'h0, v[14:11], v[16:15], v[30:24]};
            mask_level <= v[6:3] & v[10:7];
            sreq <= v[2:0] != 3'h0 ? v[23:17] : 7'h0;
            exc <= w[109:107] == 3'h0 ? 7'h01 << (w[112:110] % 3'h7) : 7'h0;
            run_case();
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            {exc, flg, sreq, pr, ena, mask_level, global_irq_enable} <= {32'h0, 72'h3, 17'h1, 4'h3, 1'b1};
            powerdown_enter <= 1'b1;
            @(posedge clk);
            powerdown_enter <= 1'b0;
            flg <= 18'h1;
            repeat (4) @(posedge clk);
            #1;
            chk({osc_enable_r, core_stall_r}, 2'b01);
            @(posedge clk);
            if (k == 0) mask_level <= 4'h2;
            else exc <= 7'h40;
            wait_until(1);
            chk(osc_enable_r, 1'b1);
        end
        @(posedge clk);
        {exc, flg} <= 25'h0;
        idle_enter <= 1'b1;
        @(posedge clk);
        idle_enter <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({osc_enable_r, core_stall_r}, 2'b11);
        @(posedge clk);
        {flg, ena, pr, mask_level} <= {18'h100, 17'h80, 72'h500000000, 4'h0};
        wait_until(2);
        chk(core_stall_r, 1'b0);
        print_verdict();
    end
endmodule
bind evi_top evi_chk evi_chk_i (.clk, .rst, .reset_any, .vector_ack, .vector_valid_r, .vector_addr_r,
    .vector_rank_r, .vector_prio_r, .is_event_r, .core_stall_r, .osc_enable_r);
`default_nettype wire
